/* File: logic/opd_core.sv */
`timescale 1ns/1ps
// Function
// RULE_01 - add with carry opcodes, NVZC updated
// RULE_02 - AND opcodes into accumulator, NZ updated
// RULE_03 - shift left, bit7 to carry, NZ
// RULE_04 - bit-clear branches 0F..7F test zero-page bit
// RULE_05 - bit-set branches 8F..FF test zero-page bit
// RULE_06 - 90/B0 branch on carry clear/set
// RULE_07 - F0/D0 branch on zero set/clear
// RULE_08 - 30/10 branch on negative set/clear
// RULE_09 - bit test sets flags, accumulator kept
// RULE_10 - signed displacement added to next address
// RULE_11 - immediate bit test touches only zero
module opd_core
	import opd_pkg::*;
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output opd_dec_t decodedCtrl,
	output opd_res_t execResult
);

	////////////////////////////////////////////////////////////////////////
	// software-visible state
	logic [7:0] opcodeReg;
	logic [15:0] operandReg;
	logic [7:0] accReg;
	logic [7:0] memReg;
	logic [3:0] flagsReg;
	logic [15:0] nextPcReg;
	opd_dec_t decReg;
	opd_res_t resReg;
	logic [31:0] prdataReg;
	logic preadyReg;
	logic pslverrReg;
	logic preadyNext;

	opd_dec_t lookupDec;
	opd_res_t execRes;

	////////////////////////////////////////////////////////////////////////
	// APB slave: one wait-free access phase, response from flops
	wire setupPhase = psel & ~penable;
	wire accessDone = psel & penable & preadyReg;
	wire wrDone = accessDone & pwrite;
	wire wrOpcode = wrDone & (paddr == OPD_ADDR_OPCODE);
	wire wrOperand = wrDone & (paddr == OPD_ADDR_OPERAND);
	wire wrState = wrDone & (paddr == OPD_ADDR_STATE);
	wire wrNextPc = wrDone & (paddr == OPD_ADDR_NEXTPC);

	logic [31:0] readWord;
	logic addrHit;

	always_comb
	begin
		readWord = 32'h0000_0000;
		addrHit = 1'b1;
		if (paddr == OPD_ADDR_OPCODE)
			readWord = {24'h00_0000, opcodeReg};
		else if (paddr == OPD_ADDR_OPERAND)
			readWord = {16'h0000, operandReg};
		else if (paddr == OPD_ADDR_STATE)
			readWord = {8'h00, memReg, 4'h0, flagsReg, accReg};
		else if (paddr == OPD_ADDR_NEXTPC)
			readWord = {16'h0000, nextPcReg};
		else if (paddr == OPD_ADDR_DECODE && !pwrite)
			readWord = {12'h000, decReg};
		else if (paddr == OPD_ADDR_RESULT && !pwrite)
			readWord = {19'h0_0000, resReg.taken, resReg.flags, resReg.result};
		else if (paddr == OPD_ADDR_TARGET && !pwrite)
			readWord = {16'h0000, resReg.target};
		else
			addrHit = 1'b0;
	end

	assign preadyNext = setupPhase ? 1'b1 : (accessDone ? 1'b0 : preadyReg);

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			preadyReg <= 1'b0;
			pslverrReg <= 1'b0;
			prdataReg <= 32'h0000_0000;
		end
		else
		begin
			preadyReg <= preadyNext;
			if (setupPhase)
			begin
				pslverrReg <= ~addrHit;
				prdataReg <= pwrite ? 32'h0000_0000 : readWord;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// writable registers
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			opcodeReg <= OPD_OPCODE_RST;
			operandReg <= OPD_OPERAND_RST;
			accReg <= OPD_ACC_RST;
			memReg <= OPD_MEM_RST;
			flagsReg <= OPD_FLAGS_RST;
			nextPcReg <= OPD_NEXTPC_RST;
		end
		else
		begin
			if (wrOpcode)
				opcodeReg <= pwdata[7:0];
			if (wrOperand)
				operandReg <= pwdata[15:0];
			if (wrState)
			begin
				accReg <= pwdata[OPD_ST_ACC_LSB +: 8];
				flagsReg <= pwdata[OPD_ST_FLAGS_LSB +: 4];
				memReg <= pwdata[OPD_ST_MEM_LSB +: 8];
			end
			if (wrNextPc)
				nextPcReg <= pwdata[15:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// decode and evaluate; both refreshed every cycle, so decReg trails an opcode write by one edge and resReg by two
	opd_lookup u_lookup (
		.opcode(opcodeReg),
		.dec(lookupDec)
	);

	opd_exec u_exec (
		.dec(decReg),
		.acc(accReg),
		.mem(memReg),
		.flagsIn(flagsReg),
		.operand(operandReg),
		.nextPc(nextPcReg),
		.res(execRes)
	);

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			decReg <= '0;
			resReg <= '0;
		end
		else
		begin
			decReg <= lookupDec;
			resReg <= execRes;
		end
	end

	assign prdata = prdataReg;
	assign pready = preadyReg;
	assign pslverr = pslverrReg;
	assign decodedCtrl = decReg;
	assign execResult = resReg;

	////////////////////////////////////////////////////////////////////////
	// checks
	wire selBit = memReg[decReg.bitSel];
	wire andZero = ((accReg & memReg) == 8'h00);
	wire [7:0] andByte = accReg & memReg;
	wire [8:0] adcSum = {1'b0, accReg} + {1'b0, memReg} + {8'h00, flagsReg[OPD_FLAG_C]};
	// expected branch target, built apart from the exec datapath
	wire [15:0] relTarget = nextPcReg + {{8{operandReg[7]}}, operandReg[7:0]};

	sequence apbOpcodeWrite;
		psel && !penable && pwrite && paddr == OPD_ADDR_OPCODE
		##1 psel && penable && pready;
	endsequence

	sequence carryClearDecoded;
		opcodeReg == 8'h90 ##1 decReg.op == OPD_OP_BRC;
	endsequence

	sequence apbSetupSeen;
		psel && !penable;
	endsequence

	sequence apbRefusedWrite;
		psel && !penable && pwrite && paddr == OPD_ADDR_DECODE;
	endsequence

	opcodeWrite_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		apbOpcodeWrite |=> (opcodeReg == $past(pwdata[7:0])) ##1 decReg.known == lookupDec.known)
		else $error("opcode write not taken at access edge");

	adcImmediate_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_01
		opcodeReg == 8'h69 |=> decReg.op == OPD_OP_ADC && decReg.mode == OPD_MD_IMM
			&& decReg.flagMask == OPD_MASK_NVZC && decReg.writesAcc)
		else $error("adc immediate decoded wrongly");

	andIndirect_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_02
		opcodeReg == 8'h31 |=> decReg.op == OPD_OP_AND && decReg.mode == OPD_MD_ZPINDY
			&& decReg.flagMask == OPD_MASK_NZ)
		else $error("and indirect indexed decoded wrongly");

	shiftCarry_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_03
		decReg.op == OPD_OP_SHL && decReg.mode == OPD_MD_ACC |=>
			resReg.flags[OPD_FLAG_C] == $past(accReg[7])
			&& resReg.result[0] == 1'b0 && resReg.result[7] == $past(accReg[6]))
		else $error("shift left result or carry wrong");

	bitClear_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_04
		decReg.op == OPD_OP_BITCLR |=> resReg.taken == !$past(selBit)
			&& resReg.flags == $past(flagsReg))
		else $error("bit clear branch decision wrong");

	bitSetMap_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_05
		opcodeReg == 8'hff |=> decReg.op == OPD_OP_BITSET && decReg.bitSel == 3'h7
			&& decReg.mode == OPD_MD_ZPREL && decReg.flagMask == OPD_MASK_NONE)
		else $error("bit set branch on bit 7 decoded wrongly");

	carryBranch_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_06
		carryClearDecoded |=> resReg.taken == !$past(flagsReg[0])
			&& resReg.flags == $past(flagsReg))
		else $error("carry clear branch decision wrong");

	zeroBranch_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_07
		opcodeReg == 8'hf0 |=> decReg.op == OPD_OP_BRC && decReg.brFlag == OPD_FLAG_Z
			&& decReg.brVal && decReg.flagMask == OPD_MASK_NONE)
		else $error("branch on zero set decoded wrongly");

	minusBranch_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_08
		opcodeReg == 8'h10 |=> decReg.op == OPD_OP_BRC && decReg.brFlag == OPD_FLAG_N
			&& !decReg.brVal)
		else $error("branch on plus decoded wrongly");

	bitTestFlags_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_09
		decReg.op == OPD_OP_BIT && decReg.mode == OPD_MD_ZP |=>
			resReg.flags[OPD_FLAG_Z] == $past(andZero)
			&& resReg.flags[OPD_FLAG_N] == $past(memReg[7])
			&& resReg.result == $past(accReg))
		else $error("bit test flags or accumulator wrong");

	branchBack_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_10
		decReg.op == OPD_OP_BITSET && selBit && operandReg[15:8] == 8'hfe |=>
			resReg.taken && resReg.target == $past(nextPcReg) - 16'h0002)
		else $error("bit branch displacement not applied");

	bitImmediate_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_11
		opcodeReg == OPD_BIT_IMM |=> decReg.op == OPD_OP_BIT && decReg.flagMask == OPD_MASK_Z
			&& !decReg.writesAcc)
		else $error("immediate bit test flag mask wrong");

	adcFlags_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_01
		decReg.op == OPD_OP_ADC |=> resReg.result == $past(adcSum[7:0])
			&& resReg.flags[OPD_FLAG_C] == $past(adcSum[8])
			&& resReg.flags[OPD_FLAG_Z] == ($past(adcSum[7:0]) == 8'h00))
		else $error("adc sum or carry wrong");

	andResult_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_02
		decReg.op == OPD_OP_AND |=> resReg.result == $past(andByte)
			&& resReg.flags[OPD_FLAG_V] == $past(flagsReg[OPD_FLAG_V])
			&& resReg.flags[OPD_FLAG_C] == $past(flagsReg[OPD_FLAG_C]))
		else $error("and result or untouched flags wrong");

	shiftMemory_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_03
		decReg.op == OPD_OP_SHL && decReg.mode != OPD_MD_ACC |=>
			resReg.result == {$past(memReg[6:0]), 1'b0} && resReg.flags[OPD_FLAG_C] == $past(memReg[7]))
		else $error("shift left memory form wrong");

	bitSetTaken_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_05
		decReg.op == OPD_OP_BITSET |=> resReg.taken == $past(selBit)
			&& resReg.flags == $past(flagsReg))
		else $error("bit set branch decision wrong");

	carrySet_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_06
		opcodeReg == 8'hb0 |=> decReg.op == OPD_OP_BRC && decReg.brFlag == OPD_FLAG_C
			&& decReg.brVal && decReg.mode == OPD_MD_REL && decReg.flagMask == OPD_MASK_NONE)
		else $error("branch on carry set decoded wrongly");

	notEqual_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_07
		opcodeReg == 8'hd0 |=> decReg.op == OPD_OP_BRC && decReg.brFlag == OPD_FLAG_Z
			&& !decReg.brVal && decReg.mode == OPD_MD_REL)
		else $error("branch on zero clear decoded wrongly");

	minusMap_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_08
		opcodeReg == 8'h30 |=> decReg.op == OPD_OP_BRC && decReg.brFlag == OPD_FLAG_N
			&& decReg.brVal && decReg.flagMask == OPD_MASK_NONE)
		else $error("branch on minus decoded wrongly");

	bitTestAcc_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_09
		opcodeReg == 8'h2c |=> decReg.op == OPD_OP_BIT && decReg.mode == OPD_MD_ABS
			&& decReg.flagMask == OPD_MASK_NVZ && !decReg.writesAcc)
		else $error("bit test absolute decoded wrongly");

	relTarget_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_10
		decReg.op == OPD_OP_BRC |=>
			resReg.target == (resReg.taken ? $past(relTarget) : $past(nextPcReg)))
		else $error("relative branch target wrong");

	// ready must drop after one access cycle or a held request would write twice
	readyPulse_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		apbSetupSeen |=> pready ##1 !pready)
		else $error("ready not a single access cycle");

	refusedWrite_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		apbRefusedWrite |=> pready && pslverr)
		else $error("write to read-only register not refused");

	unknownOvf_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		opcodeReg == 8'h50 |=> !decReg.known && decReg.op == OPD_OP_NONE)
		else $error("overflow branch wrongly decoded");

endmodule // opd_core

/* File: logic/opd_exec.sv */
`timescale 1ns/1ps
module opd_exec
	import opd_pkg::*;
(
	input opd_dec_t dec,
	input wire logic [7:0] acc,
	input wire logic [7:0] mem,
	input wire logic [3:0] flagsIn,
	input wire logic [15:0] operand,
	input wire logic [15:0] nextPc,
	output opd_res_t res
);

	logic [8:0] sum;
	logic [7:0] shlSrc;
	logic [7:0] andVal;
	logic [7:0] disp;
	logic [7:0] value;
	logic [3:0] calc;
	logic taken;

	assign sum = {1'b0, acc} + {1'b0, mem} + {8'h00, flagsIn[OPD_FLAG_C]}; // RULE_01
	assign andVal = acc & mem;
	assign shlSrc = (dec.mode == OPD_MD_ACC) ? acc : mem;
	// bit branches carry the zero-page address first, displacement second
	assign disp = (dec.mode == OPD_MD_ZPREL) ? operand[15:8] : operand[7:0]; // RULE_10

	always_comb
	begin
		value = acc;
		calc = flagsIn;
		taken = 1'b0;
		case (dec.op)
			OPD_OP_ADC:
			begin
				value = sum[7:0];
				calc = {sum[7], (~(acc[7] ^ mem[7])) & (acc[7] ^ sum[7]),
					sum[7:0] == 8'h00, sum[8]};
			end
			OPD_OP_AND:
			begin
				value = andVal; // RULE_02
				calc = {andVal[7], 1'b0, andVal == 8'h00, 1'b0};
			end
			OPD_OP_SHL:
			begin
				value = {shlSrc[6:0], 1'b0}; // RULE_03
				calc = {shlSrc[6], 1'b0, shlSrc[6:0] == 7'h00, shlSrc[7]};
			end
			OPD_OP_BIT:
			begin
				// accumulator untouched, only flags move
				calc = {mem[7], mem[6], andVal == 8'h00, 1'b0}; // RULE_09
			end
			OPD_OP_BITCLR: taken = ~mem[dec.bitSel]; // RULE_04
			OPD_OP_BITSET: taken = mem[dec.bitSel]; // RULE_05
			OPD_OP_BRC: taken = (flagsIn[dec.brFlag] == dec.brVal); // RULE_06 RULE_07 RULE_08
			default: value = acc;
		endcase
	end

	assign res.result = value;
	assign res.flags = (calc & dec.flagMask) | (flagsIn & ~dec.flagMask);
	assign res.taken = taken;
	assign res.target = taken ? (nextPc + {{8{disp[7]}}, disp}) : nextPc; // RULE_10

endmodule // opd_exec

/* File: logic/opd_lookup.sv */
`timescale 1ns/1ps
module opd_lookup
	import opd_pkg::*;
(
	input wire logic [7:0] opcode,
	output opd_dec_t dec
);

	function automatic opd_dec_t decodeOpcode(input logic [7:0] opc);
		opd_dec_t d;
		opd_mode_t am;
		opd_mode_t sm;
		opd_mode_t bm;
		d = '0;
		d.op = OPD_OP_NONE;
		d.mode = OPD_MD_NONE;
		am = opd_alu_mode(opc[4:0]);
		sm = opd_shl_mode(opc[4:0]);
		bm = opd_bit_mode(opc[4:0]);
		if (opc[7:5] == OPD_GRP_ADC && am != OPD_MD_NONE)
		begin
			d.op = OPD_OP_ADC; // RULE_01
			d.mode = am;
			d.flagMask = OPD_MASK_NVZC;
			d.writesAcc = 1'b1;
			d.known = 1'b1;
		end
		else if (opc[7:5] == OPD_GRP_AND && am != OPD_MD_NONE)
		begin
			d.op = OPD_OP_AND; // RULE_02
			d.mode = am;
			d.flagMask = OPD_MASK_NZ;
			d.writesAcc = 1'b1;
			d.known = 1'b1;
		end
		else if (opc[7:5] == OPD_GRP_SHL && sm != OPD_MD_NONE)
		begin
			d.op = OPD_OP_SHL; // RULE_03
			d.mode = sm;
			d.flagMask = OPD_MASK_NZC;
			// only the accumulator form writes back here; memory forms store the result
			d.writesAcc = (sm == OPD_MD_ACC);
			d.known = 1'b1;
		end
		else if (opc[7:5] == OPD_GRP_BIT && bm != OPD_MD_NONE)
		begin
			d.op = OPD_OP_BIT; // RULE_09
			d.mode = bm;
			d.flagMask = OPD_MASK_NVZ;
			d.known = 1'b1;
		end
		else if (opc == OPD_BIT_IMM)
		begin
			d.op = OPD_OP_BIT;
			d.mode = OPD_MD_IMM;
			d.flagMask = OPD_MASK_Z; // RULE_11
			d.known = 1'b1;
		end
		else if (opc[3:0] == OPD_BITBR_LOW)
		begin
			d.op = opc[7] ? OPD_OP_BITSET : OPD_OP_BITCLR; // RULE_04 RULE_05
			d.mode = OPD_MD_ZPREL;
			d.bitSel = opc[6:4];
			d.flagMask = OPD_MASK_NONE;
			d.known = 1'b1;
		end
		else if (opc[4:0] == OPD_FLAGBR_LOW && opc[7:6] != OPD_FLAGBR_OVF)
		begin
			d.op = OPD_OP_BRC;
			d.mode = OPD_MD_REL;
			// 1x/3x test N, 9x/Bx test C, Dx/Fx test Z; bit 5 is the wanted level
			d.brFlag = (opc[7:6] == 2'h0) ? OPD_FLAG_N :
				((opc[7:6] == 2'h2) ? OPD_FLAG_C : OPD_FLAG_Z); // RULE_06 RULE_07 RULE_08
			d.brVal = opc[5];
			d.flagMask = OPD_MASK_NONE;
			d.known = 1'b1;
		end
		return d;
	endfunction

	assign dec = decodeOpcode(opcode);

endmodule // opd_lookup

/* File: logic/opd_pkg.sv */
package opd_pkg;

	////////////////////////////////////////////////////////////////////////
	// register map, byte addresses on the APB side
	localparam logic [7:0] OPD_ADDR_OPCODE = 8'h00;
	localparam logic [7:0] OPD_ADDR_OPERAND = 8'h04;
	localparam logic [7:0] OPD_ADDR_STATE = 8'h08;
	localparam logic [7:0] OPD_ADDR_NEXTPC = 8'h0c;
	localparam logic [7:0] OPD_ADDR_DECODE = 8'h10;
	localparam logic [7:0] OPD_ADDR_RESULT = 8'h14;
	localparam logic [7:0] OPD_ADDR_TARGET = 8'h18;

	// reset values
	localparam logic [7:0] OPD_OPCODE_RST = 8'h00;
	localparam logic [15:0] OPD_OPERAND_RST = 16'h0000;
	localparam logic [7:0] OPD_ACC_RST = 8'h00;
	localparam logic [7:0] OPD_MEM_RST = 8'h00;
	localparam logic [3:0] OPD_FLAGS_RST = 4'h0;
	localparam logic [15:0] OPD_NEXTPC_RST = 16'h0000;

	// field positions in the state word
	localparam int OPD_ST_ACC_LSB = 0;
	localparam int OPD_ST_FLAGS_LSB = 8;
	localparam int OPD_ST_MEM_LSB = 16;

	////////////////////////////////////////////////////////////////////////
	// flag indices inside the four-bit {N,V,Z,C} group
	localparam logic [1:0] OPD_FLAG_C = 2'h0;
	localparam logic [1:0] OPD_FLAG_Z = 2'h1;
	localparam logic [1:0] OPD_FLAG_V = 2'h2;
	localparam logic [1:0] OPD_FLAG_N = 2'h3;

	localparam logic [3:0] OPD_MASK_NONE = 4'h0;
	localparam logic [3:0] OPD_MASK_Z = 4'h2;
	localparam logic [3:0] OPD_MASK_NZ = 4'ha;
	localparam logic [3:0] OPD_MASK_NZC = 4'hb;
	localparam logic [3:0] OPD_MASK_NVZ = 4'he;
	localparam logic [3:0] OPD_MASK_NVZC = 4'hf;

	// opcode families
	localparam logic [2:0] OPD_GRP_ADC = 3'h3;
	localparam logic [2:0] OPD_GRP_AND = 3'h1;
	localparam logic [2:0] OPD_GRP_SHL = 3'h0;
	localparam logic [2:0] OPD_GRP_BIT = 3'h1;
	localparam logic [7:0] OPD_BIT_IMM = 8'h89;
	localparam logic [3:0] OPD_BITBR_LOW = 4'hf;
	localparam logic [4:0] OPD_FLAGBR_LOW = 5'h10;
	localparam logic [1:0] OPD_FLAGBR_OVF = 2'h1;

	////////////////////////////////////////////////////////////////////////
	typedef enum logic [3:0] {
		OPD_OP_NONE = 4'h0,
		OPD_OP_ADC = 4'h1,
		OPD_OP_AND = 4'h2,
		OPD_OP_SHL = 4'h3,
		OPD_OP_BIT = 4'h4,
		OPD_OP_BITCLR = 4'h5,
		OPD_OP_BITSET = 4'h6,
		OPD_OP_BRC = 4'h7
	} opd_op_t;

	typedef enum logic [3:0] {
		OPD_MD_NONE = 4'h0,
		OPD_MD_ABS = 4'h1,
		OPD_MD_ABSX = 4'h2,
		OPD_MD_ABSY = 4'h3,
		OPD_MD_IMM = 4'h4,
		OPD_MD_ZP = 4'h5,
		OPD_MD_ZPXIND = 4'h6,
		OPD_MD_ZPX = 4'h7,
		OPD_MD_ZPIND = 4'h8,
		OPD_MD_ZPINDY = 4'h9,
		OPD_MD_ACC = 4'ha,
		OPD_MD_REL = 4'hb,
		OPD_MD_ZPREL = 4'hc
	} opd_mode_t;

	typedef struct packed {
		opd_op_t op;
		opd_mode_t mode;
		logic [3:0] flagMask;
		logic [2:0] bitSel;
		logic [1:0] brFlag;
		logic brVal;
		logic writesAcc;
		logic known;
	} opd_dec_t;

	typedef struct packed {
		logic [7:0] result;
		logic [3:0] flags;
		logic taken;
		logic [15:0] target;
	} opd_res_t;

	////////////////////////////////////////////////////////////////////////
	function automatic opd_mode_t opd_alu_mode(input logic [4:0] low);
		case (low)
			5'h0d: return OPD_MD_ABS;
			5'h1d: return OPD_MD_ABSX;
			5'h19: return OPD_MD_ABSY;
			5'h09: return OPD_MD_IMM;
			5'h05: return OPD_MD_ZP;
			5'h01: return OPD_MD_ZPXIND;
			5'h15: return OPD_MD_ZPX;
			5'h12: return OPD_MD_ZPIND;
			5'h11: return OPD_MD_ZPINDY;
			default: return OPD_MD_NONE;
		endcase
	endfunction

	function automatic opd_mode_t opd_shl_mode(input logic [4:0] low);
		case (low)
			5'h0e: return OPD_MD_ABS;
			5'h1e: return OPD_MD_ABSX;
			5'h0a: return OPD_MD_ACC;
			5'h06: return OPD_MD_ZP;
			5'h16: return OPD_MD_ZPX;
			default: return OPD_MD_NONE;
		endcase
	endfunction

	function automatic opd_mode_t opd_bit_mode(input logic [4:0] low);
		case (low)
			5'h0c: return OPD_MD_ABS;
			5'h1c: return OPD_MD_ABSX;
			5'h04: return OPD_MD_ZP;
			5'h14: return OPD_MD_ZPX;
			default: return OPD_MD_NONE;
		endcase
	endfunction

endpackage

/* File: test/opcode_decode_adc_to_bpl_tb.sv */
`timescale 1ns/1ps
module opcode_decode_adc_to_bpl_tb
	import opd_pkg::*;
();
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rdv;
	logic pready;
	logic pslverr;
	logic errv;
	logic [7:0] zpData;
	opd_dec_t decodedCtrl;
	opd_res_t execResult;
	int errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	localparam logic [7:0] ALO [9] = '{8'h0d, 8'h1d, 8'h19, 8'h09, 8'h05, 8'h01, 8'h15, 8'h12, 8'h11};
	localparam logic [7:0] SOP [5] = '{8'h0e, 8'h1e, 8'h0a, 8'h06, 8'h16};
	localparam logic [3:0] SMD [5] = '{4'h1, 4'h2, 4'ha, 4'h5, 4'h7};
	localparam logic [7:0] BOP [4] = '{8'h2c, 8'h3c, 8'h24, 8'h34};
	localparam logic [3:0] BMD [4] = '{4'h1, 4'h2, 4'h5, 4'h7};
	localparam logic [7:0] FOP [6] = '{8'h90, 8'hb0, 8'hf0, 8'hd0, 8'h30, 8'h10};
	localparam int FIX [6] = '{0, 0, 1, 1, 3, 3};
	localparam logic FVL [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};

	always #10 clk_sys = ~clk_sys;

	opd_core opd_core_inst (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.decodedCtrl(decodedCtrl), .execResult(execResult));
	opd_mem_model opd_mem_model_inst (.zpAddr(8'h12), .zpData(zpData));

	////////////////////////////////////////////////////////////////////////
	task print_verdict();
		$display("checks %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e)
		begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// request held until pready is seen high at a rising edge
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1)
			@(posedge clk_sys);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// dx = {op, mode, flagMask, writesAcc}; rx = {taken, flags, result}
	task ex(input logic [7:0] opc, input logic [23:0] st, input logic [15:0] opnd,
		input logic [12:0] dx, input logic [12:0] rx, input logic [12:0] rm,
		input logic [15:0] tx);
		apb(1'b1, OPD_ADDR_STATE, {8'h00, st});
		apb(1'b1, OPD_ADDR_OPERAND, {16'h0, opnd});
		apb(1'b1, OPD_ADDR_NEXTPC, 32'h1000);
		apb(1'b1, OPD_ADDR_OPCODE, {24'h0, opc});
		apb(1'b0, OPD_ADDR_DECODE, 32'h0);
		chk({rdv[19:8], rdv[1:0]}, {dx, 1'b1});
		apb(1'b0, OPD_ADDR_RESULT, 32'h0);
		chk(rdv[12:0] & rm, rx & rm);
		apb(1'b0, OPD_ADDR_TARGET, 32'h0);
		chk(rdv[15:0], tx);
		@(negedge clk_sys);
		chk({decodedCtrl.op, decodedCtrl.mode, decodedCtrl.flagMask, decodedCtrl.writesAcc}, dx);
		chk({execResult.taken, execResult.flags, execResult.result} & rm, rx & rm);
		chk(execResult.target, tx);
	endtask

	////////////////////////////////////////////////////////////////////////
	task s_reset();
		apb(1'b0, OPD_ADDR_OPCODE, 32'h0);
		chk(rdv, 32'h0);
		apb(1'b0, OPD_ADDR_DECODE, 32'h0);
		chk(rdv, 32'h0);
	endtask

	task s_adc_and();
		for (int i = 0; i < 9; i++)
		begin
			ex(8'h60 | ALO[i], 24'h500150, 16'h0050, {4'h1, 4'(i + 1), 4'hf, 1'b1},
				13'h0ca1, 13'h1fff, 16'h1000);
			ex(8'h20 | ALO[i], 24'h8f05f0, 16'h008f, {4'h2, 4'(i + 1), 4'ha, 1'b1},
				13'h0d80, 13'h1fff, 16'h1000);
		end
		ex(8'h69, 24'h800080, 16'h0080, 13'h029f, 13'h0700, 13'h1fff, 16'h1000);
	endtask

	task s_shift();
		for (int i = 0; i < 5; i++)
			ex(SOP[i], 24'h810481, 16'h0081, {4'h3, SMD[i], 4'hb, i == 2},
				13'h0502, 13'h1fff, 16'h1000);
	endtask

	task s_bit();
		for (int i = 0; i < 4; i++)
			ex(BOP[i], 24'hc00101, 16'h00c0, {4'h4, BMD[i], 4'he, 1'b0},
				13'h0f01, 13'h1fff, 16'h1000);
		ex(8'h89, 24'hc00101, 16'h00c0, 13'h0884, 13'h0301, 13'h1fff, 16'h1000);
	endtask

	task s_bit_branch();
		logic tk;
		for (int n = 0; n < 8; n++)
		begin
			tk = ~zpData[n];
			ex({4'(n), 4'hf}, {zpData, 16'h0a00}, 16'hfe12, 13'h0b80, {tk, 12'ha00},
				13'h1f00, tk ? 16'h0ffe : 16'h1000);
			ex({4'(n + 8), 4'hf}, {zpData, 16'h0a00}, 16'hfe12, 13'h0d80, {~tk, 12'ha00},
				13'h1f00, tk ? 16'h1000 : 16'h0ffe);
		end
	endtask

	task s_flag_branch();
		logic [3:0] fl;
		logic tk;
		for (int i = 0; i < 12; i++)
		begin
			fl = (i % 2) ? (4'h1 << FIX[i / 2]) : ~(4'h1 << FIX[i / 2]);
			tk = ((i % 2) == 1) == FVL[i / 2];
			ex(FOP[i / 2], {8'h00, 4'h0, fl, 8'h00}, 16'h007f, 13'h0f60, {tk, fl, 8'h00},
				13'h1f00, tk ? 16'h107f : 16'h1000);
		end
	endtask

	task s_refuse();
		apb(1'b1, OPD_ADDR_DECODE, 32'hffff);
		chk(errv, 1'b1);
		apb(1'b0, 8'h1c, 32'h0);
		chk({errv, rdv}, {1'b1, 32'h0});
		apb(1'b1, OPD_ADDR_OPCODE, 32'h50);
		apb(1'b0, OPD_ADDR_DECODE, 32'h0);
		chk(rdv[0], 1'b0);
	endtask

	////////////////////////////////////////////////////////////////////////
	// guard against a slave that never answers
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			errors++;
			print_verdict();
		end
	end

	initial
	begin
		repeat (4) @(posedge clk_sys);
		arst_n <= 1'b1;
		s_reset();
		s_adc_and();
		s_shift();
		s_bit();
		s_bit_branch();
		s_flag_branch();
		s_refuse();
		print_verdict();
	end
endmodule // opcode_decode_adc_to_bpl_tb

/* File: test/opd_mem_model.sv */
`timescale 1ns/1ps
module opd_mem_model
(
	input wire logic [7:0] zpAddr,
	output logic [7:0] zpData
);
	// zero-page byte fetched after the address byte; pattern arbitrary
	assign zpData = zpAddr ^ 8'h5d;
endmodule // opd_mem_model
